// *** hdl/pmic_pkg.sv ***
// Shared constants, register map and carrier types of the PMIC event and fault sequencer
package pmic_pkg;

  // ==========================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] REG_SUPPLY_STAT = 5'h00;
  localparam logic [4:0] REG_IRQ_MASK = 5'h04;
  localparam logic [4:0] REG_PEND_LO = 5'h08;
  localparam logic [4:0] REG_PEND_HI = 5'h0C;
  localparam logic [4:0] REG_FAULT_MASK = 5'h10;
  localparam logic [4:0] REG_CTRL = 5'h14;
  localparam logic [4:0] REG_MODE = 5'h18;

  // ==========================================================
  // Reset values and field positions
  localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
  localparam logic [7:0] FAULT_MASK_RST = 8'hFF;
  localparam logic [7:0] PEND_RST = 8'h00;
  localparam int unsigned CTRL_SOFT_RST_BIT = 0;
  localparam int unsigned CTRL_RESTART_BIT = 1;
  localparam int unsigned HI_THERMAL = 0;
  localparam int unsigned HI_GPIO1 = 1;
  localparam int unsigned HI_GPIO2 = 2;
  localparam int unsigned HI_ADC_DONE = 3;
  localparam int unsigned HI_ADC_RANGE = 4;
  localparam int unsigned HI_ADC_LOAD = 5;
  localparam int unsigned HI_CHARGER = 6;
  localparam int unsigned HI_POWER = 7;

  // ==========================================================
  // Bus answers and timing
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int unsigned SEQ_STEP_CYCLES = 16;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] supply_fault;
    logic thermal_fault;
    logic [1:0] gpio_irq;
    logic adc_done;
    logic adc_range;
    logic adc_load;
    logic [1:0] charge_phase;
    logic power_path_limiting;
    logic charge_suspend;
    logic thermal_foldback;
    logic ac_present;
    logic usb_present;
    logic overvoltage_protect;
    logic sys_source_usb;
    logic system_bus_sense;
    logic input_present;
    logic battery_present;
    logic hw_reset_request_n;
    logic rst_timer_expired;
  } sense_t;

  typedef enum {
    ST_OFF, ST_ENABLE, ST_SEQUENCING, ST_RESET, ST_PG_CHECK, ST_NORMAL, ST_SLEEP
  } seq_state_t;

endpackage

// *** hdl/pmic_irq_seq.sv ***
// Interrupt controller and fault/reset sequencer with an AXI4-Lite register slave
// Operation
// - Notify host on any toggle of an unmasked monitored parameter.
// - Sequencer watches system bus, input, battery, thermal and all supplies.
// - Interrupt inputs cover sequencer inputs plus charger, pack, converter events.
// - Supply fault input means output below 90% of target.
// - White LED boost fault input means its overvoltage threshold was hit.
// - Supply faults blanked during power-up, then individually maskable.
// - Unmasked supply fault forces sleep or a fresh power-up.
// - Thermal fault forces sleep; exit needs input and battery removed.
// - Reset pin low or software reset bit produces a host reset pulse.
// - Host reset pulse length set by external capacitor timer.
// - Thermal and GPIO1/GPIO2 requests each have their own mask bit.
// - Charger and power transitions interrupt in both directions.
// - Device honours host mask choices for interrupts and faults.
// - Open-drain interrupt driven low while unmasked request pends in normal.
// - While host reset is low, sources ignored and interrupt released (a pending interrupt stays driven for the first cycle of host reset).
// - Pending requests latched, readable in two byte-wide registers.
// - Masked supply causes no fault but status still shows it.
`timescale 1ns/1ps
`default_nettype none

module pmic_irq_seq #(
  parameter int unsigned SEQ_CYCLES = pmic_pkg::SEQ_STEP_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [pmic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pmic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Monitored inputs from pins and analog comparators
  input wire pmic_pkg::sense_t sense,
  // Host signalling
  output logic host_reset_output_n,
  output logic int_o,
  output logic int_oe,
  output logic irq,
  // Power sequencing controls
  output logic rst_timer_run,
  output logic supplies_en,
  output logic sleep_mode
);
  import pmic_pkg::*;

  // ==========================================================
  // Input synchronisers and previous values for toggle detection
  sense_t sense_s1_q, sense_s2_q, prev_q;

  // ==========================================================
  // State
  seq_state_t state_q, state_d;
  logic [7:0] seq_cnt_q, seq_cnt_d;
  logic [15:0] irq_mask_q, irq_mask_d;
  logic [7:0] fault_mask_q, fault_mask_d;
  logic [7:0] pend_lo_q, pend_lo_d, pend_hi_q, pend_hi_d;
  logic restart_q, restart_d;
  logic soft_req_q, soft_req_d;
  logic awready_q, awready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic host_rst_n_q, host_rst_n_d;
  logic int_oe_q, int_oe_d, irq_q;
  logic timer_run_q, timer_run_d, supplies_en_q, supplies_en_d;
  logic sleep_q, sleep_d;

  // ==========================================================
  // Combinational helpers
  logic wr_do, rd_do, irq_en, pg_active, pg_fault, any_pending;
  logic [7:0] ev_lo, ev_hi, clr_lo, clr_hi;
  logic [15:0] wmask;
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;

  always_comb begin
    wr_do = awready_q;
    rd_do = arready_q;
    wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    // Comparator outputs are meaningless while supplies ramp, so only
    // watch them once the host has been let out of reset
    pg_active = (state_q == ST_PG_CHECK) || (state_q == ST_NORMAL);
    // Fault inputs already encode below-90% for regulators and overvoltage for the boost
    pg_fault = |(sense_s2_q.supply_fault & ~fault_mask_q);
    irq_en = host_rst_n_q;
    // Toggle in either direction raises an event
    ev_lo = (sense_s2_q.supply_fault ^ prev_q.supply_fault) & {8{pg_active}};
    if (state_q == ST_PG_CHECK) begin
      // Conditions already standing at reset release are raised now
      ev_lo = ev_lo | sense_s2_q.supply_fault;
    end
    ev_hi = '0;
    ev_hi[HI_THERMAL] = sense_s2_q.thermal_fault ^ prev_q.thermal_fault;
    ev_hi[HI_GPIO1] = sense_s2_q.gpio_irq[0] ^ prev_q.gpio_irq[0];
    ev_hi[HI_GPIO2] = sense_s2_q.gpio_irq[1] ^ prev_q.gpio_irq[1];
    ev_hi[HI_ADC_DONE] = sense_s2_q.adc_done ^ prev_q.adc_done;
    ev_hi[HI_ADC_RANGE] = sense_s2_q.adc_range ^ prev_q.adc_range;
    ev_hi[HI_ADC_LOAD] = sense_s2_q.adc_load ^ prev_q.adc_load;
    ev_hi[HI_CHARGER] = |{sense_s2_q.charge_phase ^ prev_q.charge_phase,
      sense_s2_q.power_path_limiting ^ prev_q.power_path_limiting,
      sense_s2_q.charge_suspend ^ prev_q.charge_suspend,
      sense_s2_q.thermal_foldback ^ prev_q.thermal_foldback};
    ev_hi[HI_POWER] = |{sense_s2_q.ac_present ^ prev_q.ac_present,
      sense_s2_q.usb_present ^ prev_q.usb_present,
      sense_s2_q.overvoltage_protect ^ prev_q.overvoltage_protect,
      sense_s2_q.sys_source_usb ^ prev_q.sys_source_usb,
      sense_s2_q.system_bus_sense ^ prev_q.system_bus_sense,
      sense_s2_q.input_present ^ prev_q.input_present,
      sense_s2_q.battery_present ^ prev_q.battery_present};
    clr_lo = '0;
    clr_hi = '0;
    if (wr_do && s_axi_wstrb[0] && s_axi_awaddr == REG_PEND_LO) begin
      clr_lo = s_axi_wdata[7:0];
    end
    if (wr_do && s_axi_wstrb[0] && s_axi_awaddr == REG_PEND_HI) begin
      clr_hi = s_axi_wdata[7:0];
    end
    any_pending = |({pend_hi_q, pend_lo_q} & ~irq_mask_q);
  end

  // ==========================================================
  // Register file, pending latches and bus handshakes
  always_comb begin
    irq_mask_d = irq_mask_q;
    fault_mask_d = fault_mask_q;
    restart_d = restart_q;
    soft_req_d = soft_req_q & (state_q != ST_RESET);
    wr_ok = 1'b1;
    if (wr_do) begin
      case (s_axi_awaddr)
        REG_IRQ_MASK: irq_mask_d = (irq_mask_q & ~wmask) | (s_axi_wdata[15:0] & wmask);
        REG_FAULT_MASK: begin
          if (s_axi_wstrb[0]) begin
            fault_mask_d = s_axi_wdata[7:0];
          end
        end
        REG_CTRL: begin
          if (s_axi_wstrb[0]) begin
            restart_d = s_axi_wdata[CTRL_RESTART_BIT];
            soft_req_d = soft_req_d | s_axi_wdata[CTRL_SOFT_RST_BIT];
          end
        end
        REG_PEND_LO, REG_PEND_HI, REG_SUPPLY_STAT, REG_MODE: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
    end
    // Set wins over a clear in the same cycle; masked sources never latch
    pend_lo_d = (pend_lo_q & ~clr_lo) | (ev_lo & ~irq_mask_q[7:0] & {8{irq_en}});
    pend_hi_d = (pend_hi_q & ~clr_hi) | (ev_hi & ~irq_mask_q[15:8] & {8{irq_en}});
    awready_d = s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
    bvalid_d = wr_do | (bvalid_q & ~s_axi_bready);
    bresp_d = wr_do ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : bresp_q;
    rd_ok = 1'b1;
    rd_word = '0;
    case (s_axi_araddr)
      REG_SUPPLY_STAT: rd_word[7:0] = sense_s2_q.supply_fault;
      REG_IRQ_MASK: rd_word[15:0] = irq_mask_q;
      REG_PEND_LO: rd_word[7:0] = pend_lo_q;
      REG_PEND_HI: rd_word[7:0] = pend_hi_q;
      REG_FAULT_MASK: rd_word[7:0] = fault_mask_q;
      REG_CTRL: rd_word[CTRL_RESTART_BIT] = restart_q;
      REG_MODE: rd_word = 32'(state_q);
      default: rd_ok = 1'b0;
    endcase
    arready_d = s_axi_arvalid & ~arready_q & ~rvalid_q;
    rvalid_d = rd_do | (rvalid_q & ~s_axi_rready);
    rdata_d = rd_do ? rd_word : rdata_q;
    rresp_d = rd_do ? (rd_ok ? RESP_OKAY : RESP_SLVERR) : rresp_q;
  end

  // ==========================================================
  // Operating mode sequencer
  always_comb begin
    state_d = state_q;
    seq_cnt_d = seq_cnt_q;
    case (state_q)
      ST_OFF: begin
        if (sense_s2_q.input_present || sense_s2_q.battery_present) begin
          state_d = ST_ENABLE;
        end
      end
      ST_ENABLE: begin
        seq_cnt_d = '0;
        if (sense_s2_q.system_bus_sense) begin
          state_d = ST_SEQUENCING;
        end
      end
      ST_SEQUENCING: begin
        seq_cnt_d = seq_cnt_q + 8'd1;
        if (seq_cnt_q == 8'(SEQ_CYCLES - 1)) begin
          state_d = ST_RESET;
        end
      end
      ST_RESET: begin
        // Pulse ends only when the capacitor timer reports expiry
        if (sense_s2_q.rst_timer_expired) begin
          state_d = ST_PG_CHECK;
        end
      end
      ST_PG_CHECK: state_d = pg_fault ? ST_SLEEP : ST_NORMAL;
      ST_NORMAL: begin
        if (pg_fault) begin
          state_d = restart_q ? ST_ENABLE : ST_SLEEP;
        end else if (!sense_s2_q.hw_reset_request_n || soft_req_q) begin
          state_d = ST_RESET;
        end
      end
      ST_SLEEP: begin
        // Leaving sleep needs every source gone, then power-up from scratch
        if (!sense_s2_q.input_present && !sense_s2_q.battery_present) begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
    if (sense_s2_q.thermal_fault && state_q != ST_OFF && state_q != ST_SLEEP) begin
      state_d = ST_SLEEP;
    end
    host_rst_n_d = (state_d == ST_PG_CHECK) || (state_d == ST_NORMAL);
    timer_run_d = (state_d == ST_RESET);
    supplies_en_d = (state_d == ST_SEQUENCING) || (state_d == ST_RESET) || host_rst_n_d;
    sleep_d = (state_d == ST_SLEEP);
    int_oe_d = any_pending && (state_q == ST_NORMAL) && host_rst_n_q;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_s1_q <= '0;
      sense_s2_q <= '0;
      prev_q <= '0;
      state_q <= ST_OFF;
      seq_cnt_q <= '0;
      irq_mask_q <= IRQ_MASK_RST;
      fault_mask_q <= FAULT_MASK_RST;
      pend_lo_q <= PEND_RST;
      pend_hi_q <= PEND_RST;
      restart_q <= 1'b0;
      soft_req_q <= 1'b0;
      awready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      host_rst_n_q <= 1'b0;
      int_oe_q <= 1'b0;
      irq_q <= 1'b0;
      timer_run_q <= 1'b0;
      supplies_en_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      sense_s1_q <= sense;
      sense_s2_q <= sense_s1_q;
      prev_q <= sense_s2_q;
      state_q <= state_d;
      seq_cnt_q <= seq_cnt_d;
      irq_mask_q <= irq_mask_d;
      fault_mask_q <= fault_mask_d;
      pend_lo_q <= pend_lo_d;
      pend_hi_q <= pend_hi_d;
      restart_q <= restart_d;
      soft_req_q <= soft_req_d;
      awready_q <= awready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      host_rst_n_q <= host_rst_n_d;
      int_oe_q <= int_oe_d;
      irq_q <= int_oe_d;
      timer_run_q <= timer_run_d;
      supplies_en_q <= supplies_en_d;
      sleep_q <= sleep_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign host_reset_output_n = host_rst_n_q;
  // Open drain: the pad only ever pulls low
  assign int_o = 1'b0;
  assign int_oe = int_oe_q;
  assign irq = irq_q;
  assign rst_timer_run = timer_run_q;
  assign supplies_en = supplies_en_q;
  assign sleep_mode = sleep_q;

endmodule

`default_nettype wire

// *** test/pmic_host_model.sv ***
// Host-side model: open-drain interrupt wire with pull-up and host reset view
`timescale 1ns/1ps
`default_nettype none
module pmic_host_model (
  // Device pins
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic host_reset_output_n,
  // Host view
  output logic int_line,
  output logic in_reset
);
  // Pull-up wins whenever the device releases the pin
  assign int_line = int_oe ? int_o : 1'b1;
  assign in_reset = !host_reset_output_n;
endmodule
`default_nettype wire

// *** test/pmic_irq_seq_properties.sv ***
// Concurrent checks on the ports of the event and fault sequencer
`timescale 1ns/1ps
`default_nettype none
module pmic_irq_seq_properties #(
  parameter int unsigned SEQ_CYCLES = pmic_pkg::SEQ_STEP_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched signals
  input wire pmic_pkg::sense_t sense,
  input wire logic host_reset_output_n,
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic irq,
  input wire logic rst_timer_run,
  input wire logic supplies_en,
  input wire logic sleep_mode
);
  import pmic_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Interrupt line
  AST_INT_IN_RESET: assert property (!host_reset_output_n && $past(!host_reset_output_n) |-> !int_oe)
    else $error("interrupt driven during host reset");
  AST_IRQ_MATCH: assert property (irq == int_oe)
    else $error("irq and pin enable disagree");
  AST_INT_LOW_DRIVE: assert property (int_oe |-> !int_o)
    else $error("open-drain pin driven high");
  AST_INT_ONLY_UP: assert property (int_oe |-> supplies_en || $past(supplies_en))
    else $error("interrupt outside normal mode");
  // ==========================================================
  // Sequencer
  AST_TIMER_RESET: assert property (rst_timer_run |-> !host_reset_output_n)
    else $error("timer runs without host reset");
  AST_SLEEP_NO_SUPPLY: assert property (sleep_mode |-> !supplies_en)
    else $error("supplies on in sleep");
  AST_SLEEP_STAYS: assert property (sleep_mode && sense.battery_present && $past(sense.battery_present, 3)
    && $past(sense.battery_present) && $past(sense.battery_present, 2) |=> sleep_mode)
    else $error("sleep left with power present");
  AST_THERMAL_SLEEP: assert property ((supplies_en && sense.thermal_fault) [*2] |-> ##[1:6] sleep_mode)
    else $error("thermal fault did not force sleep");
  AST_HWRST_PULSE: assert property ((host_reset_output_n && !sleep_mode && !sense.hw_reset_request_n) [*2]
    |-> ##[1:6] (!host_reset_output_n || sleep_mode))
    else $error("reset pin gave no host reset");
  cover property (int_oe ##1 !int_oe);
  cover property ($rose(sleep_mode));
  cover property ($fell(host_reset_output_n) && supplies_en);
endmodule
bind pmic_irq_seq pmic_irq_seq_properties #(.SEQ_CYCLES(SEQ_CYCLES)) u_props (.aclk(aclk),
  .aresetn(aresetn), .sense(sense), .host_reset_output_n(host_reset_output_n), .int_o(int_o),
  .int_oe(int_oe), .irq(irq), .rst_timer_run(rst_timer_run), .supplies_en(supplies_en),
  .sleep_mode(sleep_mode));
`default_nettype wire

// *** test/pmic_irq_seq_bench.sv ***
// Self-checking bench of the event and fault sequencer
`timescale 1ns/1ps
`default_nettype none
module pmic_irq_seq_bench;
  import pmic_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic host_reset_output_n, int_o, int_oe, irq, rst_timer_run, supplies_en, sleep_mode;
  logic int_line, in_reset;
  sense_t sense, sv;
  int errors = 0;
  int n_checks = 0;
  int k, b;
  logic [31:0] seed = 32'h0000_0024;
  logic [31:0] last_rd = '0;
  always #10 aclk = ~aclk;
  pmic_irq_seq #(.SEQ_CYCLES(2)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense, .host_reset_output_n, .int_o, .int_oe,
    .irq, .rst_timer_run, .supplies_en, .sleep_mode);
  pmic_host_model u_host (.int_o, .int_oe, .host_reset_output_n, .int_line, .in_reset);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Pending-high bit expected for a toggle of a given sense bit
  function automatic int hi_bit(input int bit_pos);
    if (bit_pos == 18) return HI_GPIO2;
    if (bit_pos == 17) return HI_GPIO1;
    if (bit_pos >= 14) return HI_ADC_DONE + 16 - bit_pos;
    return bit_pos >= 9 ? HI_CHARGER : HI_POWER;
  endfunction
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // AXI4-Lite master: no cycle count assumed, only the bound
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] rsp);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin @(posedge aclk); n++; end while (s_axi_awready !== 1'b1 && n < 100);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 200);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) chk(0, 1, "write hang");
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er, input string m);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 100);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 200);
    s_axi_rready <= 1'b0;
    if (e !== 32'hFFFF_FFFF) chk({s_axi_rresp, s_axi_rdata}, {er, e}, m);
    if (n >= 200) chk(0, 1, "read hang");
    r = s_axi_rresp;
    last_rd = s_axi_rdata;
  endtask
  // Polls the mode register; a stale value never satisfies the wait
  task automatic wait_mode(input logic [31:0] m);
    last_rd = 32'hFFFF_FFFF;
    for (int n = 0; n < 60 && last_rd !== m; n++) rchk(REG_MODE, 32'hFFFF_FFFF, RESP_OKAY, "");
    chk(34'(last_rd), 34'(m), "mode");
  endtask
  task automatic wait_hrst_low;
    for (int n = 0; n < 60 && host_reset_output_n !== 1'b0; n++) @(posedge aclk);
    chk(34'(host_reset_output_n), 0, "host reset pulse");
  endtask
  task automatic drive(input int settle);
    sense <= sv;
    repeat (settle) @(posedge aclk);
  endtask
  task automatic toggle_check(input int bp, input bit masked);
    sv = sense_t'(sv ^ (28'h1 << bp));
    drive(9);
    rchk(REG_PEND_HI, masked ? 32'h0 : 32'h1 << hi_bit(bp), RESP_OKAY, "pending high");
    chk(34'({irq, int_line}), 34'({!masked, masked}), "interrupt line");
    wr(REG_PEND_HI, 32'h0000_00FF, r);
    repeat (3) @(posedge aclk);
    chk(34'(int_line), 1, "line released");
  endtask
  initial begin
    sv = '0;
    sv.hw_reset_request_n = 1'b1;
    sense = sv;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(REG_IRQ_MASK, 32'(IRQ_MASK_RST), RESP_OKAY, "irq mask reset");
    rchk(REG_FAULT_MASK, 32'(FAULT_MASK_RST), RESP_OKAY, "fault mask reset");
    rchk(5'h1C, 32'h0, RESP_SLVERR, "unmapped read");
    wr(5'h1C, 32'h0000_FFFF, r);
    chk(34'(r), 34'(RESP_SLVERR), "unmapped write");
    {sv.input_present, sv.battery_present, sv.system_bus_sense, sv.rst_timer_expired} = 4'hF;
    drive(1);
    wait_mode(5);
    chk(34'({host_reset_output_n, supplies_en, sleep_mode}), 34'h6, "host reset released");
    $display("test power-up done");
    for (b = 5; b <= 18; b++) begin
      seed = xs(seed);
      repeat (1 + seed[0]) toggle_check(b, 1'b0);
    end
    seed = xs(seed);
    b = 5 + int'(seed % 14);
    wr(REG_IRQ_MASK, 32'h1 << (8 + hi_bit(b)), r);
    toggle_check(b, 1'b1);
    wr(REG_IRQ_MASK, 32'h1 << (8 + HI_CHARGER), r);
    toggle_check(13, 1'b1);
    toggle_check(9, 1'b1);
    wr(REG_IRQ_MASK, 32'h0, r);
    $display("test events done");
    k = int'(seed[6:4]);
    sv.supply_fault[k] = 1'b1;
    drive(9);
    rchk(REG_SUPPLY_STAT, 32'h1 << k, RESP_OKAY, "supply status");
    rchk(REG_PEND_LO, 32'h1 << k, RESP_OKAY, "supply pending");
    rchk(REG_MODE, 32'h5, RESP_OKAY, "masked fault ignored");
    wr(REG_PEND_LO, 32'h0000_00FF, r);
    {sv.rst_timer_expired, sv.hw_reset_request_n} = 2'b00;
    drive(1);
    wait_hrst_low();
    sv.hw_reset_request_n = 1'b1;
    sv.ac_present = !sv.ac_present;
    drive(10);
    chk({32'h0, rst_timer_run, in_reset}, 34'h3, "pulse held by timer");
    chk(34'(int_line), 1, "line released in reset");
    sv.rst_timer_expired = 1'b1;
    drive(1);
    wait_mode(5);
    rchk(REG_PEND_HI, 32'h0, RESP_OKAY, "ignored in reset");
    wr(REG_CTRL, 32'h0000_0001, r);
    wait_hrst_low();
    wait_mode(5);
    $display("test resets done");
    wr(REG_CTRL, 32'h0000_0002, r);
    rchk(REG_CTRL, 32'h0000_0002, RESP_OKAY, "restart bit");
    wr(REG_FAULT_MASK, 32'(8'hFF ^ (8'h1 << k)), r);
    // Restart path must pass through the timed reset before the fault ends in sleep
    for (int n = 0; n < 60 && rst_timer_run !== 1'b1; n++) @(posedge aclk);
    chk(34'(rst_timer_run), 1, "restart on fault");
    wait_mode(6);
    {sv.input_present, sv.battery_present, sv.supply_fault} = '0;
    drive(1);
    wait_mode(0);
    {sv.input_present, sv.battery_present} = 2'b11;
    drive(1);
    wait_mode(5);
    sv.thermal_fault = 1'b1;
    drive(1);
    wait_mode(6);
    sv.input_present = 1'b0;
    drive(12);
    rchk(REG_MODE, 32'h6, RESP_OKAY, "sleep needs both removed");
    chk(34'({sleep_mode, supplies_en}), 34'h2, "sleep outputs");
    $display("test faults done");
    close_out();
  end
  initial begin
    #(20 * 60000);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
